// ==== include/ssfp_defines.svh ====
// Register map, field layout and sizing constants of the sample queue packer
`ifndef SSFP_DEFINES_SVH
`define SSFP_DEFINES_SVH

// ----------------------------------------------------------------------
// Queue sizing
// ----------------------------------------------------------------------
`define SSFP_DEPTH 10'd704
`define SSFP_LAST_PTR 10'd703
`define SSFP_EMPTY_BYTE 8'hff

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSFP_ADDR_CTRL 8'h00
`define SSFP_ADDR_OPT_CFG 8'h04
`define SSFP_ADDR_THRESH 8'h08
`define SSFP_ADDR_STATUS 8'h0c
`define SSFP_ADDR_MASK 8'h10
`define SSFP_ADDR_LEVEL 8'h14
`define SSFP_ADDR_DATA 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSFP_CTRL_STAT_BIT 0
`define SSFP_CTRL_ACLR_BIT 1
`define SSFP_SIZE_LO 0
`define SSFP_SIZE_W 3
`define SSFP_SHIFT_LO 16
`define SSFP_SHIFT_W 5
`define SSFP_ST_OVERFLOW 0
`define SSFP_ST_UNDERFLOW 1
`define SSFP_ST_LEVEL 2

// ----------------------------------------------------------------------
// Reset values and record sizes
// ----------------------------------------------------------------------
`define SSFP_CTRL_RST 2'h0
`define SSFP_OPT_CFG_RST 32'h0
`define SSFP_THRESH_RST 10'h0
`define SSFP_MASK_RST 3'h0
`define SSFP_LEN3 3'h3
`define SSFP_LEN4 3'h4

`endif

// ==== include/ssfp_pkg.sv ====
// Types shared by the sample queue packer modules
package ssfp_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EMIT = 2'b01,
        ST_CLOSE = 2'b10
    } ssfp_state_t;

    typedef enum logic [1:0] {
        KIND_CARDIAC = 2'b00,
        KIND_OPTICAL = 2'b01,
        KIND_IMPEDANCE = 2'b10
    } ssfp_kind_t;

    typedef struct packed {
        logic [9:0] rd;
        logic [9:0] cwr;
        logic [9:0] twr;
        logic [9:0] count;
        logic [9:0] pend;
    } ssfp_q_state_t;

    typedef struct packed {
        ssfp_state_t fsm;
        logic [5:0][31:0] word;
        logic [5:0][2:0] len;
        logic [2:0] widx;
        logic [2:0] bidx;
        logic last;
        logic fail;
        logic [1:0] ctrl;
        logic [31:0] opt_cfg;
        logic [9:0] thresh;
        logic [2:0] status;
        logic [2:0] mask;
        logic [31:0] rdata;
    } ssfp_top_state_t;

endpackage : ssfp_pkg

// ==== hdl/ssfp_field_fmt.sv ====
// Optical field formatter: right shift, byte width select and saturation
`timescale 1ns/1ps
`include "ssfp_defines.svh"

module ssfp_field_fmt (
    input wire logic [31:0] value,
    input wire logic [4:0] shift,
    input wire logic [2:0] size,
    output logic [31:0] word,
    output logic [2:0] len
);
    logic [31:0] shifted;
    logic [31:0] max_val;
    logic [5:0] width_bits;

    always_comb begin
        shifted = value >> shift; // RULE_07
        width_bits = {size, 3'b000};
        // Sizes above four bytes are treated as four
        if (size >= `SSFP_LEN4) begin
            max_val = 32'hffffffff;
            len = `SSFP_LEN4;
        end else begin
            max_val = (32'h1 << width_bits) - 32'h1;
            len = size; // RULE_06
        end
        if (shifted > max_val) begin
            word = max_val; // RULE_08
        end else begin
            word = shifted;
        end
    end
endmodule : ssfp_field_fmt

// ==== hdl/ssfp_byte_queue.sv ====
// Byte queue with tentative writes that are committed or rolled back per period
`timescale 1ns/1ps
`include "ssfp_defines.svh"

module ssfp_byte_queue (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic commit,
    input wire logic rollback,
    input wire logic pop,
    output logic [7:0] pop_data,
    output logic [9:0] count,
    output logic empty,
    output logic room
);
    logic [7:0] mem [0:703]; // RULE_03
    ssfp_pkg::ssfp_q_state_t s;
    ssfp_pkg::ssfp_q_state_t next_s;
    logic [9:0] c;

    function automatic logic [9:0] ptr_inc(input logic [9:0] p);
        return (p == `SSFP_LAST_PTR) ? 10'h0 : p + 10'h1;
    endfunction : ptr_inc

    assign count = s.count;
    assign empty = (s.count == 10'h0);
    // Uncommitted bytes occupy space too, so a period cannot outgrow the store
    assign room = ((s.count + s.pend) < `SSFP_DEPTH);
    assign pop_data = mem[s.rd];

    always_comb begin
        next_s = s;
        c = s.count;
        if (push && room) begin
            next_s.twr = ptr_inc(s.twr);
            next_s.pend = s.pend + 10'h1;
        end
        if (rollback) begin
            next_s.twr = s.cwr; // RULE_01
            next_s.pend = 10'h0;
        end
        if (commit) begin
            next_s.cwr = s.twr;
            next_s.pend = 10'h0;
            c = c + s.pend; // RULE_17
        end
        if (pop && !empty) begin
            next_s.rd = ptr_inc(s.rd);
            c = c - 10'h1; // RULE_17
        end
        next_s.count = c;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0; // RULE_18
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push && room) begin
            mem[s.twr] <= push_data;
        end
    end
endmodule : ssfp_byte_queue

// ==== hdl/ssfp_packer.sv ====
// Sample queue packer top: slot record serialiser, queue control and registers
// Summary of operation
// [RULE_01] Only whole periods land in the queue; short space drops period, flags overflow.
// [RULE_02] Multibyte words leave most significant byte first, least significant last.
// [RULE_03] The queue holds 704 bytes.
// [RULE_04] Reading an empty queue returns all ones and raises underflow.
// [RULE_05] Cardiac record is 24-bit sample, with optional leading status byte.
// [RULE_06] Each optical field has a byte count of 0 to 4; 0 omits it.
// [RULE_07] Each optical field is right shifted 0 to 31 bits, low bits lost.
// [RULE_08] A shifted value too big for its width is written saturated.
// [RULE_09] Optical data is pushed when its time slot finishes.
// [RULE_10] Optical fields go signal, then dark, then lit.
// [RULE_11] Channel 1 fields all precede channel 2 fields.
// [RULE_12] Impedance record is in-phase then quadrature, each 3 or 4 bytes.
// [RULE_13] Records enter the queue in time slot execution order.
// [RULE_14] Level flag set at record start once count reaches threshold; pops below clear it.
// [RULE_15] Status flags stay set until the host writes one to them; here a read of the status register also clears all three.
// [RULE_16] With auto clear on, a data read clears the level flag.
// [RULE_17] A byte count rises per push and falls per pop; here the period's pushes are added at commit.
// [RULE_18] Reset empties the queue and clears its flags.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ssfp_defines.svh"

module ssfp_packer (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic slot_valid,
    output logic slot_ready,
    input wire ssfp_pkg::ssfp_kind_t slot_kind,
    input wire logic slot_last,
    input wire logic [23:0] cardiac_sample,
    input wire logic [7:0] cardiac_status,
    input wire logic [1:0] opt_ch_en,
    input wire logic [31:0] opt1_signal,
    input wire logic [31:0] opt1_dark,
    input wire logic [31:0] opt1_lit,
    input wire logic [31:0] opt2_signal,
    input wire logic [31:0] opt2_dark,
    input wire logic [31:0] opt2_lit,
    input wire logic impedance_result_width,
    input wire logic [31:0] imp_i,
    input wire logic [31:0] imp_q
);
    ssfp_pkg::ssfp_top_state_t s;
    ssfp_pkg::ssfp_top_state_t next_s;

    // ------------------------------------------------------------------
    // Optical field formatting
    // ------------------------------------------------------------------
    // Entry order signal, dark, lit per channel, channel 1 first
    logic [31:0] opt_raw [0:5]; // RULE_10 RULE_11
    logic [31:0] opt_word [0:5];
    logic [2:0] opt_len [0:5];

    assign opt_raw[0] = opt1_signal;
    assign opt_raw[1] = opt1_dark;
    assign opt_raw[2] = opt1_lit;
    assign opt_raw[3] = opt2_signal;
    assign opt_raw[4] = opt2_dark;
    assign opt_raw[5] = opt2_lit;

    // One size and shift per field kind, shared by both channels
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gen_fmt
            localparam int FLD = g % 3;
            localparam int CH = g / 3;
            logic [2:0] eff_size;
            assign eff_size = opt_ch_en[CH] ?
                s.opt_cfg[`SSFP_SIZE_LO + `SSFP_SIZE_W * FLD +: `SSFP_SIZE_W] : 3'h0;
            ssfp_field_fmt u_fmt (
                .value(opt_raw[g]),
                .shift(s.opt_cfg[`SSFP_SHIFT_LO + `SSFP_SHIFT_W * FLD +: `SSFP_SHIFT_W]),
                .size(eff_size),
                .word(opt_word[g]),
                .len(opt_len[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Byte queue
    // ------------------------------------------------------------------
    logic q_push;
    logic [7:0] q_push_data;
    logic q_commit;
    logic q_rollback;
    logic q_pop;
    logic [7:0] q_pop_data;
    logic [9:0] q_count;
    logic q_empty;
    logic q_room;

    ssfp_byte_queue u_queue (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .push(q_push),
        .push_data(q_push_data),
        .commit(q_commit),
        .rollback(q_rollback),
        .pop(q_pop),
        .pop_data(q_pop_data),
        .count(q_count),
        .empty(q_empty),
        .room(q_room)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic data_rd;
    logic status_rd;
    logic status_wr;

    assign data_rd = reg_rd && (reg_addr == `SSFP_ADDR_DATA);
    assign status_rd = reg_rd && (reg_addr == `SSFP_ADDR_STATUS);
    assign status_wr = reg_wr && (reg_addr == `SSFP_ADDR_STATUS);
    assign q_pop = data_rd && !q_empty;

    assign slot_ready = (s.fsm == ssfp_pkg::ST_IDLE);
    assign reg_rdata = s.rdata;
    assign irq = |(s.status & s.mask);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [2:0] set_st;
    logic [2:0] sel;
    logic [31:0] cur_word;
    logic [31:0] shifted_word;

    always_comb begin
        next_s = s;
        set_st = 3'h0;
        q_push = 1'b0;
        q_push_data = 8'h0;
        q_commit = 1'b0;
        q_rollback = 1'b0;
        cur_word = s.word[s.widx];
        sel = s.len[s.widx] - 3'h1 - s.bidx;
        shifted_word = cur_word >> {sel, 3'b000}; // RULE_02

        unique case (s.fsm)
            ssfp_pkg::ST_IDLE: begin
                // Records are taken strictly in arrival order, one slot at a time
                if (slot_valid) begin // RULE_09 RULE_13
                    next_s.word = '0;
                    next_s.len = '0;
                    next_s.widx = 3'h0;
                    next_s.bidx = 3'h0;
                    next_s.last = slot_last;
                    next_s.fsm = ssfp_pkg::ST_EMIT;
                    // Reaching the threshold counts, so a whole record is already waiting
                    if (q_count >= s.thresh) begin
                        set_st[`SSFP_ST_LEVEL] = 1'b1; // RULE_14
                    end
                    case (slot_kind)
                        ssfp_pkg::KIND_CARDIAC: begin
                            next_s.word[0] = {cardiac_status, cardiac_sample}; // RULE_05
                            next_s.len[0] = s.ctrl[`SSFP_CTRL_STAT_BIT] ?
                                `SSFP_LEN4 : `SSFP_LEN3;
                        end
                        ssfp_pkg::KIND_OPTICAL: begin
                            for (int i = 0; i < 6; i++) begin
                                next_s.word[i] = opt_word[i];
                                next_s.len[i] = opt_len[i];
                            end
                        end
                        ssfp_pkg::KIND_IMPEDANCE: begin
                            next_s.word[0] = imp_i; // RULE_12
                            next_s.word[1] = imp_q;
                            next_s.len[0] = impedance_result_width ? `SSFP_LEN4 : `SSFP_LEN3;
                            next_s.len[1] = impedance_result_width ? `SSFP_LEN4 : `SSFP_LEN3;
                        end
                        default: begin
                            // Unknown kind contributes no bytes
                            next_s.len = '0;
                        end
                    endcase
                end
            end
            ssfp_pkg::ST_EMIT: begin
                if (s.bidx >= s.len[s.widx]) begin
                    next_s.bidx = 3'h0;
                    if (s.widx == 3'h5) begin
                        next_s.fsm = s.last ? ssfp_pkg::ST_CLOSE : ssfp_pkg::ST_IDLE;
                    end else begin
                        next_s.widx = s.widx + 3'h1;
                    end
                end else begin
                    next_s.bidx = s.bidx + 3'h1;
                    // After the first failure the rest of the period is skipped
                    if (!s.fail && q_room) begin
                        q_push = 1'b1;
                        q_push_data = shifted_word[7:0];
                    end else begin
                        next_s.fail = 1'b1; // RULE_01
                    end
                end
            end
            ssfp_pkg::ST_CLOSE: begin
                if (s.fail) begin
                    q_rollback = 1'b1; // RULE_01
                    set_st[`SSFP_ST_OVERFLOW] = 1'b1;
                end else begin
                    q_commit = 1'b1;
                end
                next_s.fail = 1'b0;
                next_s.fsm = ssfp_pkg::ST_IDLE;
            end
        endcase

        if (data_rd && q_empty) begin
            set_st[`SSFP_ST_UNDERFLOW] = 1'b1; // RULE_04
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `SSFP_ADDR_CTRL: next_s.ctrl = reg_wdata[1:0];
                `SSFP_ADDR_OPT_CFG: next_s.opt_cfg = reg_wdata;
                `SSFP_ADDR_THRESH: next_s.thresh = reg_wdata[9:0];
                `SSFP_ADDR_MASK: next_s.mask = reg_wdata[2:0];
                default: next_s.opt_cfg = s.opt_cfg;
            endcase
        end

        // Flag clears first, hardware sets last so a same-cycle event survives
        if (status_rd) begin
            next_s.status = 3'h0;
        end
        if (status_wr) begin
            next_s.status = next_s.status & ~reg_wdata[2:0]; // RULE_15
        end
        if (data_rd && s.ctrl[`SSFP_CTRL_ACLR_BIT]) begin
            next_s.status[`SSFP_ST_LEVEL] = 1'b0; // RULE_16
        end
        // Only a pop tests the threshold to clear it, so raising the threshold leaves the flag alone
        if (q_pop && ((q_count - 10'h1) < s.thresh)) begin
            next_s.status[`SSFP_ST_LEVEL] = 1'b0; // RULE_14
        end
        next_s.status = next_s.status | set_st;

        // Read data stands for the single cycle after the strobe
        next_s.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `SSFP_ADDR_CTRL: next_s.rdata = {30'h0, s.ctrl};
                `SSFP_ADDR_OPT_CFG: next_s.rdata = s.opt_cfg;
                `SSFP_ADDR_THRESH: next_s.rdata = {22'h0, s.thresh};
                `SSFP_ADDR_STATUS: next_s.rdata = {29'h0, s.status};
                `SSFP_ADDR_MASK: next_s.rdata = {29'h0, s.mask};
                `SSFP_ADDR_LEVEL: next_s.rdata = {22'h0, q_count};
                `SSFP_ADDR_DATA: next_s.rdata = {24'h0, q_empty ? `SSFP_EMPTY_BYTE : q_pop_data};
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0; // RULE_18
            s.fsm <= ssfp_pkg::ST_IDLE;
            s.ctrl <= `SSFP_CTRL_RST;
            s.opt_cfg <= `SSFP_OPT_CFG_RST;
            s.thresh <= `SSFP_THRESH_RST;
            s.mask <= `SSFP_MASK_RST;
        end else begin
            s <= next_s;
        end
    end
endmodule : ssfp_packer

// ==== testbench/ssfp_packer_asserts.sv ====
// Port level checks of the sample queue packer
`timescale 1ns/1ps
`include "ssfp_defines.svh"

module ssfp_chk (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic slot_valid,
    input wire logic slot_ready
);
    // ----
    // Shadow of the mask register
    // ----
    logic [2:0] mask_sh;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_sh <= 3'h0;
        end else if (reg_wr && reg_addr == `SSFP_ADDR_MASK) begin
            mask_sh <= reg_wdata[2:0];
        end
    end

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    masked_quiet_a: assert property (mask_sh == 3'h0 |-> !irq)
        else $error("irq high with all sources masked");
    irq_hold_a: assert property (irq && !reg_rd && !reg_wr |=> irq)
        else $error("irq dropped without a host access");
    stat_clear_a: assert property (
        reg_rd && reg_addr == `SSFP_ADDR_STATUS && slot_ready && !slot_valid |=> !irq)
        else $error("irq still high after status read");
    accept_busy_a: assert property (slot_valid && slot_ready |=> !slot_ready [*6])
        else $error("record stream ready again too early");
    accept_done_a: assert property (slot_valid && slot_ready |-> ##[7:40] slot_ready)
        else $error("record stream stuck busy");
    data_byte_a: assert property (
        reg_rd && reg_addr == `SSFP_ADDR_DATA |=> reg_rdata[31:8] == 24'h0)
        else $error("queue read wider than a byte");
    level_cap_a: assert property (
        reg_rd && reg_addr == `SSFP_ADDR_LEVEL |=> reg_rdata <= 32'h2c0)
        else $error("queue level above capacity");
    reset_clean_a: assert property (!$past(reset_n) |-> slot_ready && !irq)
        else $error("state not clean after reset");
endmodule : ssfp_chk

// ==== testbench/ssfp_slot_src.sv ====
// Time slot record source standing in for the measurement engine
`timescale 1ns/1ps

module ssfp_slot_src (
    input wire logic core_clk,
    input wire logic slot_ready,
    output logic slot_valid,
    output ssfp_pkg::ssfp_kind_t slot_kind,
    output logic slot_last,
    output logic [31:0] w [6]
);
    initial begin
        slot_valid = 1'b0;
        slot_kind = ssfp_pkg::KIND_CARDIAC;
        slot_last = 1'b0;
        foreach (w[i]) w[i] = 32'h0;
    end

    // Offer held until taken or 60 cycles pass; data inverted afterwards so stale values never match
    task automatic offer(input ssfp_pkg::ssfp_kind_t k, input logic l,
                         input logic [31:0] d [6], output logic ok);
        int n;
        n = 0;
        slot_valid <= 1'b1;
        slot_kind <= k;
        slot_last <= l;
        foreach (d[i]) w[i] <= d[i];
        #1;
        while (!slot_ready && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        ok = slot_ready;
        @(posedge core_clk);
        slot_valid <= 1'b0;
        foreach (d[i]) w[i] <= ~d[i];
        @(posedge core_clk);
    endtask : offer
endmodule : ssfp_slot_src

// ==== testbench/ssfp_packer_tb.sv ====
// Self-checking bench of the sample queue packer
`timescale 1ns/1ps
`include "ssfp_defines.svh"

module ssfp_packer_tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    logic slot_valid;
    logic slot_ready;
    logic slot_last;
    ssfp_pkg::ssfp_kind_t slot_kind;
    logic [1:0] opt_ch_en = 2'h3;
    logic impedance_result_width = 1'b0;
    logic [31:0] w [6];
    logic [31:0] d [6];
    logic [7:0] exp_q [$];
    logic [31:0] v;
    int err_total = 0;
    int n_compared = 0;

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    ssfp_packer dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .slot_valid(slot_valid), .slot_ready(slot_ready),
        .slot_kind(slot_kind), .slot_last(slot_last),
        .cardiac_sample(w[0][23:0]), .cardiac_status(w[1][7:0]), .opt_ch_en(opt_ch_en),
        .opt1_signal(w[0]), .opt1_dark(w[1]), .opt1_lit(w[2]),
        .opt2_signal(w[3]), .opt2_dark(w[4]), .opt2_lit(w[5]),
        .impedance_result_width(impedance_result_width), .imp_i(w[0]), .imp_q(w[1])
    );

    ssfp_slot_src src (
        .core_clk(core_clk), .slot_ready(slot_ready), .slot_valid(slot_valid),
        .slot_kind(slot_kind), .slot_last(slot_last), .w(w)
    );

    // ----
    // Access tasks
    // ----
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        x = reg_rdata;
        @(posedge core_clk);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, v);
        chk("register read", exp, v);
    endtask : rchk

    task automatic pop_chk();
        while (exp_q.size() > 0) begin
            rchk(`SSFP_ADDR_DATA, {24'h0, exp_q.pop_front()});
        end
    endtask : pop_chk

    // Offer one record, wait 40 cycles, then check that the packer is idle again
    task automatic send(input ssfp_pkg::ssfp_kind_t k, input logic l);
        logic ok;
        src.offer(k, l, d, ok);
        if (!ok) begin
            chk("record taken", 32'h1, 32'h0);
            end_sim();
        end
        repeat (40) @(posedge core_clk);
        chk("slot_ready", 32'h1, {31'h0, slot_ready});
    endtask : send

    // ----
    // Test sequence
    // ----
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rchk(`SSFP_ADDR_LEVEL, 32'h0);
        wr(`SSFP_ADDR_MASK, 32'h2);
        rchk(`SSFP_ADDR_DATA, 32'hff);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`SSFP_ADDR_STATUS, 32'h2);
        rchk(`SSFP_ADDR_STATUS, 32'h0);
        rchk(8'h1c, 32'h0);
        $display("test reset and empty read done");

        d = '{32'h00123456, 32'h000000a5, 32'h0, 32'h0, 32'h0, 32'h0};
        wr(`SSFP_ADDR_CTRL, 32'h1);
        send(ssfp_pkg::KIND_CARDIAC, 1'b1);
        rchk(`SSFP_ADDR_LEVEL, 32'h4);
        exp_q = '{8'ha5, 8'h12, 8'h34, 8'h56};
        pop_chk();
        wr(`SSFP_ADDR_CTRL, 32'h0);
        send(ssfp_pkg::KIND_CARDIAC, 1'b1);
        exp_q = '{8'h12, 8'h34, 8'h56};
        pop_chk();
        $display("test cardiac done");

        d = '{32'h00012340, 32'h1ff, 32'h80000000, 32'h00100000, 32'h7f, 32'hffffffff};
        wr(`SSFP_ADDR_OPT_CFG, 32'h7c04010a);
        send(ssfp_pkg::KIND_OPTICAL, 1'b1);
        exp_q = '{8'h12, 8'h34, 8'hff, 8'h0, 8'h0, 8'h0, 8'h1,
                  8'hff, 8'hff, 8'h7f, 8'h0, 8'h0, 8'h0, 8'h1};
        pop_chk();
        opt_ch_en <= 2'h1;
        wr(`SSFP_ADDR_OPT_CFG, 32'h00040002);
        rchk(`SSFP_ADDR_OPT_CFG, 32'h00040002);
        send(ssfp_pkg::KIND_OPTICAL, 1'b1);
        exp_q = '{8'h12, 8'h34};
        pop_chk();
        $display("test optical done");

        d = '{32'h11abcdef, 32'h55667788, 32'h0, 32'h0, 32'h0, 32'h0};
        send(ssfp_pkg::KIND_CARDIAC, 1'b0);
        rchk(`SSFP_ADDR_LEVEL, 32'h0);
        send(ssfp_pkg::KIND_IMPEDANCE, 1'b0);
        impedance_result_width <= 1'b1;
        send(ssfp_pkg::KIND_IMPEDANCE, 1'b1);
        exp_q = '{8'hab, 8'hcd, 8'hef, 8'hab, 8'hcd, 8'hef, 8'h66, 8'h77, 8'h88,
                  8'h11, 8'hab, 8'hcd, 8'hef, 8'h55, 8'h66, 8'h77, 8'h88};
        pop_chk();
        // Channel 2 alone, oversized signal field taken as four bytes
        opt_ch_en <= 2'h2;
        wr(`SSFP_ADDR_OPT_CFG, 32'h00000007);
        send(ssfp_pkg::KIND_OPTICAL, 1'b1);
        exp_q = '{8'h0, 8'h0, 8'h0, 8'h0};
        pop_chk();
        $display("test period order done");

        wr(`SSFP_ADDR_THRESH, 32'h3);
        rchk(`SSFP_ADDR_THRESH, 32'h3);
        // A zero threshold is reached at every record start
        rchk(`SSFP_ADDR_STATUS, 32'h4);
        wr(`SSFP_ADDR_MASK, 32'h5);
        rchk(`SSFP_ADDR_MASK, 32'h5);
        send(ssfp_pkg::KIND_CARDIAC, 1'b1);
        rchk(`SSFP_ADDR_STATUS, 32'h0);
        send(ssfp_pkg::KIND_CARDIAC, 1'b1);
        rchk(`SSFP_ADDR_STATUS, 32'h4);
        send(ssfp_pkg::KIND_CARDIAC, 1'b1);
        repeat (9) rd(`SSFP_ADDR_DATA, v);
        rchk(`SSFP_ADDR_STATUS, 32'h0);
        repeat (88) send(ssfp_pkg::KIND_IMPEDANCE, 1'b1);
        rchk(`SSFP_ADDR_LEVEL, 32'h2c0);
        rchk(`SSFP_ADDR_STATUS, 32'h4);
        send(ssfp_pkg::KIND_IMPEDANCE, 1'b1);
        rchk(`SSFP_ADDR_LEVEL, 32'h2c0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`SSFP_ADDR_CTRL, 32'h2);
        rchk(`SSFP_ADDR_CTRL, 32'h2);
        rchk(`SSFP_ADDR_DATA, 32'h11);
        rchk(`SSFP_ADDR_STATUS, 32'h1);
        repeat (703) rd(`SSFP_ADDR_DATA, v);
        // The spare kind code must add no bytes
        send(ssfp_pkg::ssfp_kind_t'(2'h3), 1'b1);
        rchk(`SSFP_ADDR_LEVEL, 32'h0);
        $display("test fill and overflow done");
        end_sim();
    end
endmodule : ssfp_packer_tb

bind ssfp_packer ssfp_chk chk_i (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .slot_valid(slot_valid), .slot_ready(slot_ready)
);
